// file: verilog/abmsg_top.sv
`timescale 1ns/1ps
`default_nettype none
module abmsg_top #(
	parameter int AW = 24
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// work queue post
	input wire logic post_valid_i,
	input wire logic [3:0] post_queue_i,
	input wire logic [AW-1:0] post_addr_i,
	output logic post_ready_o,
	output logic post_reject_o,
	// shared memory master
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [AW-1:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i,
	// scsi message engine
	output logic msg_valid_o,
	output logic msg_port_o,
	output logic [2:0] msg_target_o,
	output logic [2:0] msg_lun_o,
	output logic [7:0] msg_code_o,
	input wire logic msg_ready_i,
	input wire logic msg_done_i,
	input wire logic msg_fail_i,
	// backplane interrupt pins
	input wire logic vme_iack_i,
	input wire logic [2:0] vme_iack_level_i,
	output logic [7:1] vme_irq_oe_o,
	output logic [7:0] vme_vector_o,
	output logic vme_vector_valid_o,
	// completion
	output logic busy_o,
	output logic cmd_done_o,
	output logic [15:0] last_status_o
);
	import abmsg_pkg::*;

	// ----------------------------------------
	// fetch order of the host-written words
	// ----------------------------------------
	function automatic logic [4:0] fetch_ofs(input logic [2:0] idx);
		case (idx)
			3'h0: fetch_ofs = OFS_CODE;
			3'h1: fetch_ofs = OFS_OPTIONS;
			3'h2: fetch_ofs = OFS_VECTORS;
			3'h3: fetch_ofs = OFS_LEVEL;
			default: fetch_ofs = OFS_UNIT;
		endcase
	endfunction

	function automatic logic [AW-1:0] word_addr(input logic [AW-1:0] base,
		input logic [4:0] ofs);
		word_addr = AW'(base + AW'(ofs));
	endfunction

	typedef struct packed {
		abmsg_state_t state;
		logic [AW-1:0] base;
		logic [2:0] idx;
		logic [NUM_FETCH-1:0][15:0] words;
		logic [15:0] status;
		logic reject;
		logic mem_start;
		logic mem_we;
		logic [AW-1:0] mem_addr;
		logic [15:0] mem_wdata;
		logic msg_valid;
		logic msg_port;
		logic [2:0] msg_target;
		logic [2:0] msg_lun;
		logic irq_start;
		logic [2:0] irq_level;
		logic [7:0] irq_vector;
		logic done;
	} abmsg_top_t;

	abmsg_top_t r_reg, r_next;

	abmsg_mem_if #(.AW(AW)) mem_ch ();
	abmsg_irq_if irq_ch ();

	// ----------------------------------------
	// named views of the fetched words
	// ----------------------------------------
	logic [15:0] w_code;
	logic [15:0] w_opt;
	logic [15:0] w_vec;
	logic [15:0] w_lvl;
	logic [15:0] w_unit;
	assign w_code = r_reg.words[0];
	assign w_opt = r_reg.words[1];
	assign w_vec = r_reg.words[2];
	assign w_lvl = r_reg.words[3];
	assign w_unit = r_reg.words[4];

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.reject = 1'b0;
		r_next.mem_start = 1'b0;
		r_next.irq_start = 1'b0;
		r_next.done = 1'b0;
		case (r_reg.state)
			ST_IDLE: begin
				if (post_valid_i) begin
					// other queues may not carry this command
					if (post_queue_i == WQ_MASTER) begin
						r_next.base = post_addr_i;
						r_next.idx = 3'h0;
						r_next.mem_start = 1'b1;
						r_next.mem_we = 1'b0;
						r_next.mem_addr = word_addr(post_addr_i, fetch_ofs(3'h0));
						r_next.state = ST_FETCH;
					end else begin
						r_next.reject = 1'b1;
					end
				end
			end
			ST_FETCH: begin
				if (mem_ch.done) begin
					r_next.words[r_reg.idx] = mem_ch.rdata;
					if (r_reg.idx == 3'(NUM_FETCH - 1)) begin
						// reserved bits are not looked at
						r_next.msg_target = mem_ch.rdata[UNIT_ID_LSB +: 3];
						r_next.msg_lun = mem_ch.rdata[UNIT_LUN_LSB +: 3];
						r_next.msg_port = mem_ch.rdata[UNIT_BUS_BIT];
						if (w_code == CMD_ABORT_MSG) begin
							r_next.msg_valid = 1'b1;
							r_next.state = ST_MSG_REQ;
						end else begin
							r_next.status = ERR_BAD_CMD;
							r_next.mem_start = 1'b1;
							r_next.mem_we = 1'b1;
							r_next.mem_addr = word_addr(r_reg.base, OFS_STATUS);
							r_next.mem_wdata = ERR_BAD_CMD;
							r_next.state = ST_WR_STATUS;
						end
					end else begin
						r_next.idx = 3'(r_reg.idx + 3'h1);
						r_next.mem_start = 1'b1;
						r_next.mem_addr = word_addr(r_reg.base, fetch_ofs(3'(r_reg.idx + 3'h1)));
					end
				end
			end
			ST_MSG_REQ: begin
				if (msg_ready_i) begin
					r_next.msg_valid = 1'b0;
					r_next.state = ST_MSG_WAIT;
				end
			end
			ST_MSG_WAIT: begin
				if (msg_done_i) begin
					// an idle unit is reported as plain success by the engine
					r_next.status = msg_fail_i ? ERR_SCSI_FAIL : STATUS_OK;
					r_next.mem_start = 1'b1;
					r_next.mem_we = 1'b1;
					r_next.mem_addr = word_addr(r_reg.base, OFS_STATUS);
					r_next.mem_wdata = msg_fail_i ? ERR_SCSI_FAIL : STATUS_OK;
					r_next.state = ST_WR_STATUS;
				end
			end
			ST_WR_STATUS: begin
				// interrupt only after the status word is in memory
				if (mem_ch.done) begin
					if (w_opt[OPT_IE_BIT]) begin
						r_next.irq_start = 1'b1;
						r_next.irq_level = w_lvl[LVL_LSB +: 3];
						r_next.irq_vector = (r_reg.status == STATUS_OK) ?
							w_vec[VEC_NORM_LSB +: 8] : w_vec[VEC_ERR_LSB +: 8];
						r_next.state = ST_IRQ_WAIT;
					end else begin
						r_next.done = 1'b1;
						r_next.state = ST_IDLE;
					end
				end
			end
			ST_IRQ_WAIT: begin
				if (irq_ch.done) begin
					r_next.done = 1'b1;
					r_next.state = ST_IDLE;
				end
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			r_reg <= '0;
			r_reg.state <= ST_IDLE;
			r_reg.status <= STATUS_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// channels
	// ----------------------------------------
	assign mem_ch.start = r_reg.mem_start;
	assign mem_ch.we = r_reg.mem_we;
	assign mem_ch.addr = r_reg.mem_addr;
	assign mem_ch.wdata = r_reg.mem_wdata;
	assign irq_ch.start = r_reg.irq_start;
	assign irq_ch.level = r_reg.irq_level;
	assign irq_ch.vector = r_reg.irq_vector;

	abmsg_mem_port #(.AW(AW)) u_mem (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.ch(mem_ch.port),
		.mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o),
		.mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i)
	);

	abmsg_irq_req u_irq (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.ch(irq_ch.port),
		.vme_iack_i(vme_iack_i),
		.vme_iack_level_i(vme_iack_level_i),
		.vme_irq_oe_o(vme_irq_oe_o),
		.vme_vector_o(vme_vector_o),
		.vme_vector_valid_o(vme_vector_valid_o)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign post_ready_o = (r_reg.state == ST_IDLE);
	assign post_reject_o = r_reg.reject;
	assign msg_valid_o = r_reg.msg_valid;
	assign msg_port_o = r_reg.msg_port;
	assign msg_target_o = r_reg.msg_target;
	assign msg_lun_o = r_reg.msg_lun;
	assign msg_code_o = SCSI_MSG_ABORT;
	assign busy_o = (r_reg.state != ST_IDLE);
	assign cmd_done_o = r_reg.done;
	assign last_status_o = r_reg.status;
endmodule
`default_nettype wire

// file: inc/abmsg_pkg.sv
// Summary of operation
// - A block posted on work queue zero whose command code word equals the abort code runs the abort operation.
// - As initiator the adapter sends the target a message to drop its current operation.
// - Aborting a unit with nothing in progress for this initiator is not an error.
// - Options bit zero enables the completion interrupt; when clear, none is raised.
// - The vector word low byte is the error vector and its high byte the normal vector.
// - The completion interrupt uses the bus request level in bits zero to two of the level word.
// - Unit address bits zero to two give the target ID and bits three to five the unit number.
// - Unit address bit six selects port zero (primary) or port one (secondary).
// - At completion a return status word is written: zero on success, else an error code.
package abmsg_pkg;
	// ----------------------------------------
	// command block layout (word offsets)
	// ----------------------------------------
	localparam logic [4:0] OFS_CODE = 5'h00;
	localparam logic [4:0] OFS_OPTIONS = 5'h01;
	localparam logic [4:0] OFS_STATUS = 5'h02;
	localparam logic [4:0] OFS_VECTORS = 5'h04;
	localparam logic [4:0] OFS_LEVEL = 5'h05;
	localparam logic [4:0] OFS_UNIT = 5'h0f;
	localparam int NUM_FETCH = 5;
	// ----------------------------------------
	// codes and fields
	// ----------------------------------------
	localparam logic [15:0] CMD_ABORT_MSG = 16'h004e;
	localparam logic [3:0] WQ_MASTER = 4'h0;
	localparam logic [7:0] SCSI_MSG_ABORT = 8'h06;
	localparam int OPT_IE_BIT = 0;
	localparam int VEC_ERR_LSB = 0;
	localparam int VEC_NORM_LSB = 8;
	localparam int LVL_LSB = 0;
	localparam int UNIT_ID_LSB = 0;
	localparam int UNIT_LUN_LSB = 3;
	localparam int UNIT_BUS_BIT = 6;
	localparam logic [15:0] STATUS_OK = 16'h0000;
	localparam logic [15:0] ERR_BAD_CMD = 16'h0001;
	localparam logic [15:0] ERR_SCSI_FAIL = 16'h0002;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_MSG_REQ = 3'b010,
		ST_MSG_WAIT = 3'b011,
		ST_WR_STATUS = 3'b100,
		ST_IRQ_WAIT = 3'b101
	} abmsg_state_t;
endpackage

// file: inc/abmsg_if.sv
`timescale 1ns/1ps
`default_nettype none
// single-word block memory channel
interface abmsg_mem_if #(parameter int AW = 24);
	logic start;
	logic we;
	logic [AW-1:0] addr;
	logic [15:0] wdata;
	logic done;
	logic [15:0] rdata;
	modport ctl (output start, we, addr, wdata, input done, rdata);
	modport port (input start, we, addr, wdata, output done, rdata);
endinterface

// completion interrupt request channel
interface abmsg_irq_if;
	logic start;
	logic [2:0] level;
	logic [7:0] vector;
	logic done;
	modport ctl (output start, level, vector, input done);
	modport port (input start, level, vector, output done);
endinterface
`default_nettype wire

// file: verilog/abmsg_mem_port.sv
`timescale 1ns/1ps
`default_nettype none
module abmsg_mem_port #(
	parameter int AW = 24
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// channel from the sequencer
	abmsg_mem_if.port ch,
	// shared memory master
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [AW-1:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i
);
	import abmsg_pkg::*;

	typedef struct packed {
		logic busy;
		logic we;
		logic [AW-1:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic done;
	} abmsg_mp_t;

	abmsg_mp_t r_reg, r_next;

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (!r_reg.busy && ch.start) begin
			r_next.busy = 1'b1;
			r_next.we = ch.we;
			r_next.addr = ch.addr;
			r_next.wdata = ch.wdata;
		end else if (r_reg.busy && mem_ack_i) begin
			// request held until the memory answers
			r_next.busy = 1'b0;
			r_next.done = 1'b1;
			if (!r_reg.we) begin
				r_next.rdata = mem_rdata_i;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign mem_req_o = r_reg.busy;
	assign mem_we_o = r_reg.we;
	assign mem_addr_o = r_reg.addr;
	assign mem_wdata_o = r_reg.wdata;
	assign ch.done = r_reg.done;
	assign ch.rdata = r_reg.rdata;
endmodule
`default_nettype wire

// file: verilog/abmsg_irq_req.sv
`timescale 1ns/1ps
`default_nettype none
module abmsg_irq_req (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// channel from the sequencer
	abmsg_irq_if.port ch,
	// backplane interrupt pins
	input wire logic vme_iack_i,
	input wire logic [2:0] vme_iack_level_i,
	output logic [7:1] vme_irq_oe_o,
	output logic [7:0] vme_vector_o,
	output logic vme_vector_valid_o
);
	import abmsg_pkg::*;

	typedef struct packed {
		logic iack_s1;
		logic iack_s2;
		logic [2:0] lvl_s1;
		logic [2:0] lvl_s2;
		logic active;
		logic [2:0] level;
		logic [7:0] vector;
		logic vec_valid;
		logic [7:1] irq_oe;
		logic done;
	} abmsg_irq_t;

	abmsg_irq_t r_reg, r_next;

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		// pins pass two flops before use
		r_next.iack_s1 = vme_iack_i;
		r_next.iack_s2 = r_reg.iack_s1;
		r_next.lvl_s1 = vme_iack_level_i;
		r_next.lvl_s2 = r_reg.lvl_s1;
		if (!r_reg.iack_s2) begin
			r_next.vec_valid = 1'b0;
		end
		if (ch.start && !r_reg.active) begin
			r_next.vector = ch.vector;
			r_next.level = ch.level;
			// level zero means no bus request at all
			if (ch.level == 3'h0) begin
				r_next.done = 1'b1;
			end else begin
				r_next.active = 1'b1;
			end
		end else if (r_reg.active && r_reg.iack_s2 && r_reg.lvl_s2 == r_reg.level) begin
			r_next.active = 1'b0;
			r_next.vec_valid = 1'b1;
			r_next.done = 1'b1;
		end
		r_next.irq_oe = '0;
		if (r_next.active) begin
			r_next.irq_oe[r_next.level] = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign vme_irq_oe_o = r_reg.irq_oe;
	assign vme_vector_o = r_reg.vector;
	assign vme_vector_valid_o = r_reg.vec_valid;
	assign ch.done = r_reg.done;
endmodule
`default_nettype wire

// file: testbench/abmsg_props.sv
`timescale 1ns/1ps
`default_nettype none
module abmsg_props
	import abmsg_pkg::*;
#(
	parameter int AW = 24
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// post and memory
	input wire logic post_valid_i,
	input wire logic [3:0] post_queue_i,
	input wire logic [AW-1:0] post_addr_i,
	input wire logic post_ready_o,
	input wire logic post_reject_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [AW-1:0] mem_addr_o,
	input wire logic [15:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i,
	// message, interrupt, completion
	input wire logic msg_valid_o,
	input wire logic msg_port_o,
	input wire logic [2:0] msg_target_o,
	input wire logic [2:0] msg_lun_o,
	input wire logic [7:0] msg_code_o,
	input wire logic msg_done_i,
	input wire logic msg_fail_i,
	input wire logic [7:1] vme_irq_oe_o,
	input wire logic [7:0] vme_vector_o,
	input wire logic vme_vector_valid_o,
	input wire logic busy_o,
	input wire logic cmd_done_o,
	input wire logic [15:0] last_status_o
);
	logic [AW-1:0] base;
	logic [15:0] code, opt, vec, lvl, unit, wst;
	logic fl, sw;
	wire logic take = post_valid_i && post_ready_o;
	wire logic rd = mem_req_o && mem_ack_i && !mem_we_o;
	wire logic wr = mem_req_o && mem_ack_i && mem_we_o;
	// ----
	// shadow of the fetched block
	// ----
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			{base, code, opt, vec, lvl, unit, wst, fl, sw} <= '0;
		end else begin
			if (take) begin
				base <= post_addr_i;
				fl <= 1'b0;
				sw <= 1'b0;
			end
			if (rd && mem_addr_o == base + AW'(OFS_CODE)) code <= mem_rdata_i;
			if (rd && mem_addr_o == base + AW'(OFS_OPTIONS)) opt <= mem_rdata_i;
			if (rd && mem_addr_o == base + AW'(OFS_VECTORS)) vec <= mem_rdata_i;
			if (rd && mem_addr_o == base + AW'(OFS_LEVEL)) lvl <= mem_rdata_i;
			if (rd && mem_addr_o == base + AW'(OFS_UNIT)) unit <= mem_rdata_i;
			if (wr) begin
				sw <= 1'b1;
				wst <= mem_wdata_o;
			end
			if (msg_done_i) fl <= msg_fail_i;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// the start pulse passes one register before the memory port raises its request
	a_post_fetch: assert property (take && post_queue_i == WQ_MASTER |-> ##2
		mem_req_o && busy_o && !mem_we_o && mem_addr_o == base)
		else $error("post on queue zero did not start fetch");
	a_post_refuse: assert property (take && post_queue_i != WQ_MASTER |=> post_reject_o && !busy_o)
		else $error("post on other queue not refused");
	a_abort_only: assert property (msg_valid_o |-> code == CMD_ABORT_MSG)
		else $error("message sent for other code");
	a_abort_code: assert property ($rose(msg_valid_o) |-> msg_code_o == SCSI_MSG_ABORT)
		else $error("wrong message code");
	a_msg_target: assert property (msg_valid_o |-> msg_target_o == unit[2:0] && msg_lun_o == unit[5:3])
		else $error("target or unit wrong");
	a_msg_port: assert property (msg_valid_o |-> msg_port_o == unit[6])
		else $error("port wrong");
	a_status_word: assert property (mem_req_o && mem_we_o |-> mem_addr_o == base + AW'(OFS_STATUS) && mem_wdata_o == (code != CMD_ABORT_MSG ? ERR_BAD_CMD : fl ? ERR_SCSI_FAIL : STATUS_OK))
		else $error("status write wrong");
	a_empty_unit: assert property (msg_done_i && !msg_fail_i |-> ##2
		mem_req_o && mem_we_o && mem_wdata_o == STATUS_OK)
		else $error("clean abort not reported as success");
	a_irq_enable: assert property ($rose(|vme_irq_oe_o) |-> opt[0])
		else $error("interrupt while disabled");
	// done from the port is registered once more in the sequencer
	a_ie_clear: assert property (wr && !opt[0] |-> ##2 cmd_done_o && vme_irq_oe_o == '0)
		else $error("no prompt completion without interrupt");
	a_irq_level: assert property (|vme_irq_oe_o |-> {vme_irq_oe_o, 1'b0} == 8'h01 << lvl[2:0])
		else $error("wrong request line");
	a_status_first: assert property (|vme_irq_oe_o |-> sw)
		else $error("interrupt before status write");
	a_vector_pick: assert property ($rose(vme_vector_valid_o) |-> vme_vector_o == (wst == STATUS_OK ? vec[15:8] : vec[7:0]))
		else $error("wrong vector");
	a_done_status: assert property (cmd_done_o |-> last_status_o == wst)
		else $error("last status differs from written");
	c_irq: cover property (wr && opt[0]);
	c_reject: cover property ($rose(post_reject_o));
	c_fail: cover property (msg_done_i && msg_fail_i);
endmodule
bind abmsg_top abmsg_props #(.AW(AW)) u_props (.core_clk_i, .reset_i, .post_valid_i,
	.post_queue_i, .post_addr_i, .post_ready_o, .post_reject_o, .mem_req_o, .mem_we_o,
	.mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .msg_valid_o, .msg_port_o,
	.msg_target_o, .msg_lun_o, .msg_code_o, .msg_done_i, .msg_fail_i, .vme_irq_oe_o,
	.vme_vector_o, .vme_vector_valid_o, .busy_o, .cmd_done_o, .last_status_o);
`default_nettype wire

// file: testbench/abmsg_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module abmsg_far_model (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// memory, targets, interrupter
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [23:0] mem_addr_i,
	input wire logic [15:0] mem_wdata_i,
	output logic mem_ack_o,
	output logic [15:0] mem_rdata_o,
	input wire logic msg_valid_i,
	input wire logic [6:0] msg_unit_i,
	output logic msg_ready_o,
	output logic msg_done_o,
	output logic msg_fail_o,
	input wire logic [7:1] vme_irq_oe_i,
	input wire logic [7:0] vme_vector_i,
	input wire logic vme_vector_valid_i,
	output logic vme_iack_o,
	output logic [2:0] vme_iack_level_o,
	// scenario controls
	input wire logic slow_i,
	input wire logic fail_i
);
	logic [15:0] mem [0:31];
	logic [1:0] dly;
	logic [2:0] cnt, lvl_seen;
	logic vv_q;
	logic [6:0] unit_seen;
	logic [7:0] vec_seen;
	int n_msg;
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			{mem_ack_o, dly, cnt, msg_ready_o, msg_done_o, msg_fail_o, vme_iack_o, vv_q} <= '0;
			mem_rdata_o <= 16'h5a5a;
			vme_iack_level_o <= 3'h0;
			n_msg <= 0;
		end else begin
			// idle data lines toggle so a stale word is never taken as good
			mem_ack_o <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o;
			if (mem_req_i && !mem_ack_o) begin
				dly <= dly + 2'h1;
				if (!slow_i || dly == 2'h3) begin
					dly <= 2'h0;
					mem_ack_o <= 1'b1;
					mem_rdata_o <= mem[mem_addr_i[4:0]];
					if (mem_we_i) mem[mem_addr_i[4:0]] <= mem_wdata_i;
				end
			end
			// target frees the bus with no status phase, only done
			msg_ready_o <= msg_valid_i && !msg_ready_o;
			msg_done_o <= cnt == 3'h1;
			msg_fail_o <= cnt == 3'h1 ? fail_i : ~msg_fail_o;
			if (cnt != 3'h0) cnt <= cnt - 3'h1;
			if (msg_valid_i && !msg_ready_o) begin
				cnt <= 3'h4;
				n_msg <= n_msg + 1;
				unit_seen <= msg_unit_i;
			end
			vv_q <= vme_vector_valid_i;
			if (vme_vector_valid_i && !vv_q) begin
				vec_seen <= vme_vector_i;
				lvl_seen <= vme_iack_level_o;
			end
			if (vme_vector_valid_i) vme_iack_o <= 1'b0;
			else if (|vme_irq_oe_i) vme_iack_o <= 1'b1;
			if (!(|vme_irq_oe_i)) vme_iack_level_o <= ~vme_iack_level_o;
			for (int k = 1; k < 8; k++) if (vme_irq_oe_i[k]) vme_iack_level_o <= 3'(k);
		end
	end
endmodule
`default_nettype wire

// file: testbench/abmsg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module abmsg_tb_top;
	import abmsg_pkg::*;
	logic core_clk_i, reset_i, post_valid_i, post_ready_o, post_reject_o, busy_o, cmd_done_o;
	logic mem_req_o, mem_we_o, mem_ack_i, msg_valid_o, msg_port_o, msg_ready_i, msg_done_i;
	logic msg_fail_i, vme_iack_i, vme_vector_valid_o, slow, fail;
	logic [3:0] post_queue_i;
	logic [23:0] post_addr_i, mem_addr_o;
	logic [15:0] mem_wdata_o, mem_rdata_i, last_status_o;
	logic [2:0] msg_target_o, msg_lun_o, vme_iack_level_i;
	logic [7:0] msg_code_o, vme_vector_o;
	logic [7:1] vme_irq_oe_o;
	int err_total, n_tests;
	abmsg_top DUT (.core_clk_i, .reset_i, .post_valid_i, .post_queue_i, .post_addr_i,
		.post_ready_o, .post_reject_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
		.mem_ack_i, .mem_rdata_i, .msg_valid_o, .msg_port_o, .msg_target_o, .msg_lun_o,
		.msg_code_o, .msg_ready_i, .msg_done_i, .msg_fail_i, .vme_iack_i, .vme_iack_level_i,
		.vme_irq_oe_o, .vme_vector_o, .vme_vector_valid_o, .busy_o, .cmd_done_o, .last_status_o);
	abmsg_far_model m (.core_clk_i, .reset_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i), .msg_valid_i(msg_valid_o),
		.msg_unit_i({msg_port_o, msg_lun_o, msg_target_o}), .msg_ready_o(msg_ready_i),
		.msg_done_o(msg_done_i), .msg_fail_o(msg_fail_i), .vme_irq_oe_i(vme_irq_oe_o),
		.vme_vector_i(vme_vector_o), .vme_vector_valid_i(vme_vector_valid_o),
		.vme_iack_o(vme_iack_i), .vme_iack_level_o(vme_iack_level_i), .slow_i(slow), .fail_i(fail));
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic post(input logic [3:0] q);
		@(posedge core_clk_i);
		post_valid_i <= 1'b1;
		post_queue_i <= q;
		@(posedge core_clk_i);
		post_valid_i <= 1'b0;
	endtask
	// one whole command; reserved words stay zero from the start
	task automatic run(input logic [15:0] code, opt, vec, lvl, unit, input logic f, s,
		input logic [15:0] exp);
		m.mem[0] = code;
		m.mem[1] = opt;
		m.mem[4] = vec;
		m.mem[5] = lvl;
		m.mem[15] = unit;
		// stale status from the previous run must not pass for a fresh write
		m.mem[2] = 16'hffff;
		fail <= f;
		slow <= s;
		post(WQ_MASTER);
		for (int i = 0; i < 300 && cmd_done_o !== 1'b1; i++) @(negedge core_clk_i);
		cmp({15'h0, cmd_done_o}, 16'h1);
		cmp(last_status_o, exp);
		cmp(m.mem[2], exp);
	endtask
	task automatic t_levels;
		for (int l = 1; l < 8; l++) begin
			run(CMD_ABORT_MSG, 16'h1, 16'hc33c, 16'(l), 16'h0013, 1'b0, l[0], STATUS_OK);
			cmp(16'(m.vec_seen), 16'hc3);
			cmp(16'(m.lvl_seen), 16'(l));
		end
		$display("test levels done");
	endtask
	task automatic t_ports;
		for (int p = 0; p < 2; p++) begin
			run(CMD_ABORT_MSG, 16'h0, 16'h7e81, 16'h0, 16'(p * 64 + 21), 1'b0, 1'b0, STATUS_OK);
			cmp(16'(m.unit_seen), 16'(p * 64 + 21));
		end
		cmp(16'(m.vec_seen), 16'hc3);
		$display("test ports done");
	endtask
	task automatic t_errors;
		int n;
		run(CMD_ABORT_MSG, 16'h1, 16'hc33c, 16'h2, 16'h0040, 1'b1, 1'b1, ERR_SCSI_FAIL);
		cmp(16'(m.vec_seen), 16'h3c);
		n = m.n_msg;
		run(16'h004d, 16'h1, 16'h5aa5, 16'h4, 16'h0040, 1'b0, 1'b0, ERR_BAD_CMD);
		cmp(16'(m.n_msg - n), 16'h0);
		cmp(16'(m.vec_seen), 16'ha5);
		$display("test errors done");
	endtask
	task automatic t_reject;
		logic seen;
		seen = 1'b0;
		post(4'h5);
		repeat (2) begin
			@(negedge core_clk_i);
			seen = seen | post_reject_o;
		end
		cmp({15'h0, seen}, 16'h1);
		cmp({15'h0, busy_o}, 16'h0);
		$display("test reject done");
	endtask
	initial begin
		reset_i = 1'b1;
		post_valid_i = 1'b0;
		post_queue_i = 4'h0;
		post_addr_i = 24'h001020;
		slow = 1'b0;
		fail = 1'b0;
		err_total = 0;
		n_tests = 0;
		for (int i = 0; i < 32; i++) m.mem[i] = 16'h0000;
		repeat (3) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(negedge core_clk_i);
		cmp({5'h0, post_ready_o, busy_o, vme_irq_oe_o, mem_req_o, msg_valid_o}, 16'h400);
		t_levels();
		t_ports();
		t_errors();
		t_reject();
		final_report();
	end
	// bench needs about 500 cycles; allow forty times that
	initial begin
		#80000;
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
